// ==== acm_defs.svh ====
// Purpose: shared constants for the audio port clock master block
// Assumes: included by bare name; definitions only
// Notes: byte address of a register is four times its index
`ifndef ACM_DEFS_SVH
`define ACM_DEFS_SVH

// register indices and bus decode
`define ACM_IDX_CFG_A 8'h13
`define ACM_IDX_CFG_B 8'h14
`define ACM_IDX_STS 8'h15
`define ACM_IDX_REF 8'h16
`define ACM_IDX_W 8
`define ACM_ADDR_HI 31
`define ACM_ADDR_TOP 10

// reset values
`define ACM_RST_CFG_A 8'h02
`define ACM_RST_CFG_B 8'h48
`define ACM_RST_STS 8'hFF
`define ACM_RST_REF 8'h02

// field positions of config a
`define ACM_B_ROLE 7
`define ACM_B_AUTO 6
`define ACM_B_PLLDIS 5
`define ACM_B_GATE 4
`define ACM_B_FAM 3
`define ACM_F_REFC 2:0
// field positions of config b
`define ACM_F_RATE 7:4
`define ACM_F_RATIO 3:0
// field positions of the reference select register
`define ACM_B_REFMODE 3
`define ACM_F_REFRATIO 2:0

// code limits
`define ACM_RATE_MAX 4'h8
`define ACM_RATIO_MAX 4'hC
`define ACM_CODE_BAD 4'hF

// timing
`define ACM_CLK_HZ 50000000
`define ACM_PCT 100
`define ACM_TOL_PCT 10
`define ACM_SLOWEST_HZ 7350
`define ACM_MON_LIMIT ((`ACM_CLK_HZ / `ACM_SLOWEST_HZ) * \
  (`ACM_PCT + `ACM_TOL_PCT) / `ACM_PCT)

`endif

// ==== acm_pkg.sv ====
// Purpose: types and code tables for the audio port clock block
// Assumes: acm_defs.svh on the include path
// Notes: tables follow the programming encodings of the port
`default_nettype none
`include "acm_defs.svh"
package acm_pkg;

  typedef enum logic [0:0] {
    ACM_GEN_IDLE = 1'b0,
    ACM_GEN_RUN = 1'b1
  } acm_gen_state_t;

  // frame rate in Hz for a rate code; fam 1 picks the 44.1 kHz family
  function automatic int acm_rate_hz(input int code, input bit fam);
    int r;
    r = 0;
    case (code)
      0: r = fam ? 7350 : 8000;
      1: r = fam ? 14700 : 16000;
      2: r = fam ? 22050 : 24000;
      3: r = fam ? 29400 : 32000;
      4: r = fam ? 44100 : 48000;
      5: r = fam ? 88200 : 96000;
      6: r = fam ? 176400 : 192000;
      7: r = fam ? 352800 : 384000;
      8: r = fam ? 705600 : 768000;
      default: r = 0;
    endcase
    return r;
  endfunction : acm_rate_hz

  // bit clocks per frame for a ratio code
  function automatic int acm_ratio(input int code);
    int r;
    r = 0;
    case (code)
      0: r = 16;
      1: r = 24;
      2: r = 32;
      3: r = 48;
      4: r = 64;
      5: r = 96;
      6: r = 128;
      7: r = 192;
      8: r = 256;
      9: r = 384;
      10: r = 512;
      11: r = 1024;
      12: r = 2048;
      default: r = 0;
    endcase
    return r;
  endfunction : acm_ratio

endpackage : acm_pkg
`default_nettype wire

// ==== acm_clkgen.sv ====
// Purpose: master mode bit clock and frame sync generator
// Assumes: codes are legal whenever run is high
// Notes: phase accumulator gives the exact average bit clock rate up to half the clock rate
`timescale 1ns/1ps
`default_nettype none
`include "acm_defs.svh"
module acm_clkgen import acm_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic family,
  input wire logic [3:0] rate_code,
  input wire logic [3:0] ratio_code,
  // generated clocks
  output logic bclk,
  output logic fsync
);

  localparam logic [33:0] CLK_HZ = 34'(`ACM_CLK_HZ);

  acm_gen_state_t state_reg;
  logic [33:0] acc_reg;
  logic [33:0] step;
  logic [33:0] sum;
  logic tick;
  logic [10:0] cnt_reg;
  logic [10:0] last_bit;

  always_comb begin
    step = 34'(longint'(acm_rate_hz(int'(rate_code), family)) *
      longint'(acm_ratio(int'(ratio_code))) * 2);
    sum = acc_reg + step;
    last_bit = 11'(acm_ratio(int'(ratio_code)) - 1);
    // at or above half the clock rate the bit clock toggles every cycle
    tick = (state_reg == ACM_GEN_RUN) && ((step >= CLK_HZ) || (sum >= CLK_HZ));
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ACM_GEN_IDLE;
      acc_reg <= '0;
    end else if (!run) begin
      state_reg <= ACM_GEN_IDLE;
      acc_reg <= '0;
    end else begin
      case (state_reg)
        ACM_GEN_IDLE: state_reg <= ACM_GEN_RUN;
        ACM_GEN_RUN: begin
          if (step < CLK_HZ) begin
            acc_reg <= tick ? sum - CLK_HZ : sum;
          end
        end
        default: state_reg <= ACM_GEN_IDLE;
      endcase
    end
  end

  // frame: fsync high for the first bit clock period of each frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk <= 1'b0;
      fsync <= 1'b0;
      cnt_reg <= '0;
    end else if (!run) begin
      bclk <= 1'b0;
      fsync <= 1'b0;
      cnt_reg <= '0;
    end else if (state_reg == ACM_GEN_IDLE) begin
      fsync <= 1'b1;
      cnt_reg <= '0;
    end else if (tick) begin
      bclk <= ~bclk;
      if (bclk) begin
        // a shrunk ratio ends the frame now instead of after a wrap
        if (cnt_reg >= last_bit) begin
          cnt_reg <= '0;
          fsync <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 11'h001;
          fsync <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper: bit clock rises between frame starts
  logic bclk_d, fsync_d, seen_fs;
  logic [3:0] ratio_d;
  logic [11:0] rises;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_d <= 1'b0;
      fsync_d <= 1'b0;
      seen_fs <= 1'b0;
      ratio_d <= 4'h0;
      rises <= '0;
    end else begin
      bclk_d <= bclk;
      fsync_d <= fsync;
      ratio_d <= ratio_code;
      // a frame cut by a ratio change is not a full frame
      if (!run || ratio_code != ratio_d) begin
        seen_fs <= 1'b0;
        rises <= '0;
      end else if (fsync && !fsync_d) begin
        seen_fs <= 1'b1;
        rises <= '0;
      end else if (bclk && !bclk_d) begin
        rises <= rises + 12'h001;
      end
    end
  end

  property p_frame_len;
    @(posedge clk) disable iff (!rst_n)
    (run && $stable(ratio_code) && seen_fs && fsync && !fsync_d) |->
      (rises == 12'(acm_ratio(int'(ratio_code))));
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("bit clocks per frame differ from the programmed ratio");

endmodule : acm_clkgen
`default_nettype wire

// ==== acm_mon.sv ====
// Purpose: measures frame rate and bit clocks per frame on the port
// Assumes: levels arrive already synchronised to clk
// Notes: a frame is measured between two frame sync rising edges
`timescale 1ns/1ps
`default_nettype none
`include "acm_defs.svh"
module acm_mon import acm_pkg::*; #(
  parameter int MON_LIMIT = `ACM_MON_LIMIT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // observed port levels
  input wire logic bclk_lvl,
  input wire logic fsync_lvl,
  // detected codes, rate high nibble
  output logic [7:0] status
);

  logic bclk_d, fsync_d, seen_reg;
  logic [15:0] cyc_reg;
  logic [11:0] bit_reg;
  logic fs_rise, bc_rise;
  logic [3:0] rate_det, ratio_det;

  function automatic logic [3:0] rate_of(input logic [15:0] n);
    logic [3:0] r;
    int lo, hi;
    r = `ACM_CODE_BAD;
    for (int k = 0; k <= int'(`ACM_RATE_MAX); k++) begin
      lo = (`ACM_CLK_HZ / acm_rate_hz(k, 1'b0)) *
        (`ACM_PCT - `ACM_TOL_PCT) / `ACM_PCT;
      hi = (`ACM_CLK_HZ / acm_rate_hz(k, 1'b1)) *
        (`ACM_PCT + `ACM_TOL_PCT) / `ACM_PCT;
      if (int'(n) >= lo && int'(n) <= hi) r = 4'(k);
    end
    return r;
  endfunction : rate_of

  function automatic logic [3:0] ratio_of(input logic [11:0] n);
    logic [3:0] r;
    r = `ACM_CODE_BAD;
    for (int k = 0; k <= int'(`ACM_RATIO_MAX); k++) begin
      if (int'(n) == acm_ratio(k)) r = 4'(k);
    end
    return r;
  endfunction : ratio_of

  assign fs_rise = fsync_lvl && !fsync_d;
  assign bc_rise = bclk_lvl && !bclk_d;
  assign rate_det = rate_of(cyc_reg);
  assign ratio_det = ratio_of(bit_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_d <= 1'b0;
      fsync_d <= 1'b0;
    end else begin
      bclk_d <= bclk_lvl;
      fsync_d <= fsync_lvl;
    end
  end

  // counters saturate so a stopped bus reads invalid, not stale
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_reg <= 16'h0000;
      bit_reg <= 12'h000;
      seen_reg <= 1'b0;
      status <= `ACM_RST_STS;
    end else if (fs_rise) begin
      cyc_reg <= 16'h0001;
      bit_reg <= bc_rise ? 12'h001 : 12'h000;
      seen_reg <= 1'b1;
      if (seen_reg) status <= {rate_det, ratio_det};
    end else if (int'(cyc_reg) >= MON_LIMIT) begin
      seen_reg <= 1'b0;
      status <= {`ACM_CODE_BAD, `ACM_CODE_BAD};
    end else begin
      cyc_reg <= cyc_reg + 16'h0001;
      if (bc_rise && bit_reg != 12'hFFF) bit_reg <= bit_reg + 12'h001;
    end
  end

  property p_ratio_legal;
    @(posedge clk) disable iff (!rst_n)
    (status[3:0] != `ACM_CODE_BAD) |-> (status[3:0] <= `ACM_RATIO_MAX);
  endproperty
  a_ratio_legal: assert property (p_ratio_legal)
    else $error("monitor reports a reserved ratio code");

endmodule : acm_mon
`default_nettype wire

// ==== acm_top.sv ====
// Purpose: clock configuration and master clock drive of the audio port
// Assumes: AHB-Lite single word transfers, 50 MHz clock
// Notes: zero wait state slave; responses are always OKAY
//
// What this block does
// - role bit: 0 slave inputs, 1 drive clocks
// - auto bit 0 derives dividers and PLL
// - auto mode: PLL runs unless disable bit set
// - gate bit stops outgoing clocks in master
// - family bit picks 48k or 44.1k base
// - reference code maps to eight crystal frequencies
// - reference code used only master, mode zero
// - rate codes 0-8 map 8k to 768k
// - slave auto mode ignores rate and ratio
// - ratio codes 0-12 map 16 to 2048
// - read-only monitor status resets to all ones
// - status: rate nibble high, ratio nibble low
// - mode one: reference from frame-rate multiple
`timescale 1ns/1ps
`default_nettype none
`include "acm_defs.svh"
module acm_top import acm_pkg::*; #(
  parameter int MON_LIMIT = `ACM_MON_LIMIT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // bit clock pin
  input wire logic bclk_i,
  output logic bclk_o,
  output logic bclk_oe,
  // frame sync pin
  input wire logic fsync_i,
  output logic fsync_o,
  output logic fsync_oe,
  // clock tree controls
  output logic auto_clk_en,
  output logic pll_en,
  output logic rate_family,
  output logic ref_freq_valid,
  output logic [2:0] ref_freq_code,
  output logic ref_ratio_valid,
  output logic [2:0] ref_ratio_code,
  output logic frame_cfg_used
);

  logic [7:0] cfg_a_reg, cfg_b_reg, ref_reg, sts;
  logic addr_ok, acc_phase, wr_pend_reg, byp;
  logic [`ACM_IDX_W-1:0] idx, wr_idx_reg;
  logic [7:0] rd_val;
  logic is_master, is_auto, run;
  logic [2:0] bclk_s, fsync_s;
  logic bclk_lvl, fsync_lvl, gen_bclk, gen_fsync;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign idx = haddr[`ACM_ADDR_TOP-1:2];
  assign addr_ok = (haddr[`ACM_ADDR_HI:`ACM_ADDR_TOP] == '0) &&
    (haddr[1:0] == 2'h0);
  assign acc_phase = hsel && htrans[1] && hready;
  assign byp = wr_pend_reg && (wr_idx_reg == idx);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= '0;
    end else if (hready) begin
      wr_pend_reg <= acc_phase && hwrite && addr_ok;
      wr_idx_reg <= idx;
    end
  end

  // bypass covers a read right behind a write to the same word
  always_comb begin
    rd_val = 8'h00;
    case (idx)
      `ACM_IDX_CFG_A: rd_val = byp ? hwdata[7:0] : cfg_a_reg;
      `ACM_IDX_CFG_B: rd_val = byp ? hwdata[7:0] : cfg_b_reg;
      `ACM_IDX_STS: rd_val = sts;
      `ACM_IDX_REF: begin
        rd_val = byp ? {4'h0, hwdata[`ACM_B_REFMODE:0]} : ref_reg;
      end
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (acc_phase && !hwrite) begin
      hrdata <= addr_ok ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers; status takes no writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_a_reg <= `ACM_RST_CFG_A;
    end else if (wr_pend_reg && wr_idx_reg == `ACM_IDX_CFG_A) begin
      cfg_a_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_b_reg <= `ACM_RST_CFG_B;
    end else if (wr_pend_reg && wr_idx_reg == `ACM_IDX_CFG_B) begin
      cfg_b_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_reg <= `ACM_RST_REF;
    end else if (wr_pend_reg && wr_idx_reg == `ACM_IDX_REF) begin
      ref_reg <= {4'h0, hwdata[`ACM_B_REFMODE:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // derived controls
  assign is_master = cfg_a_reg[`ACM_B_ROLE];
  assign is_auto = !cfg_a_reg[`ACM_B_AUTO];
  // reserved codes hold the clocks still rather than guess a rate
  assign run = is_master && !cfg_a_reg[`ACM_B_GATE] &&
    (cfg_b_reg[`ACM_F_RATE] <= `ACM_RATE_MAX) &&
    (cfg_b_reg[`ACM_F_RATIO] <= `ACM_RATIO_MAX);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_oe <= 1'b0;
      fsync_oe <= 1'b0;
    end else begin
      bclk_oe <= is_master;
      fsync_oe <= is_master;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_clk_en <= 1'b0;
      pll_en <= 1'b0;
    end else begin
      auto_clk_en <= is_auto;
      pll_en <= is_auto && !cfg_a_reg[`ACM_B_PLLDIS];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_family <= 1'b0;
      frame_cfg_used <= 1'b0;
    end else begin
      rate_family <= cfg_a_reg[`ACM_B_FAM];
      frame_cfg_used <= is_master || !is_auto;
    end
  end

  // reference source: crystal code or multiple of frame rate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_freq_valid <= 1'b0;
      ref_freq_code <= 3'h0;
      ref_ratio_valid <= 1'b0;
      ref_ratio_code <= 3'h0;
    end else begin
      ref_freq_valid <= is_master && is_auto &&
        !ref_reg[`ACM_B_REFMODE];
      ref_freq_code <= cfg_a_reg[`ACM_F_REFC];
      ref_ratio_valid <= is_master && is_auto &&
        ref_reg[`ACM_B_REFMODE];
      ref_ratio_code <= ref_reg[`ACM_F_REFRATIO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: level moves once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_s <= 3'h0;
      fsync_s <= 3'h0;
    end else begin
      bclk_s <= {bclk_s[1:0], bclk_i};
      fsync_s <= {fsync_s[1:0], fsync_i};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_lvl <= 1'b0;
      fsync_lvl <= 1'b0;
    end else begin
      if (bclk_s[1] == bclk_s[2]) bclk_lvl <= bclk_s[2];
      if (fsync_s[1] == fsync_s[2]) fsync_lvl <= fsync_s[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  acm_clkgen u_gen (
    .clk(clk),
    .rst_n(rst_n),
    .run(run),
    .family(cfg_a_reg[`ACM_B_FAM]),
    .rate_code(cfg_b_reg[`ACM_F_RATE]),
    .ratio_code(cfg_b_reg[`ACM_F_RATIO]),
    .bclk(gen_bclk),
    .fsync(gen_fsync)
  );

  assign bclk_o = gen_bclk;
  assign fsync_o = gen_fsync;

  // the monitor watches whichever end drives the bus
  acm_mon #(.MON_LIMIT(MON_LIMIT)) u_mon (
    .clk(clk),
    .rst_n(rst_n),
    .bclk_lvl(is_master ? gen_bclk : bclk_lvl),
    .fsync_lvl(is_master ? gen_fsync : fsync_lvl),
    .status(sts)
  );

  ////////////////////////////////////////////////////////////////////////////
  property p_role_drive;
    @(posedge clk) disable iff (!rst_n)
    ##1 (bclk_oe == $past(is_master)) && (fsync_oe == bclk_oe);
  endproperty
  a_role_drive: assert property (p_role_drive)
    else $error("pin drive does not follow the role bit");

  property p_auto;
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> auto_clk_en == !$past(cfg_a_reg[`ACM_B_AUTO]);
  endproperty
  a_auto: assert property (p_auto)
    else $error("auto clock enable does not follow its bit");

  property p_pll;
    @(posedge clk) disable iff (!rst_n)
    (is_auto && cfg_a_reg[`ACM_B_PLLDIS]) |=> !pll_en;
  endproperty
  a_pll: assert property (p_pll)
    else $error("pll left running while disabled");

  property p_gate;
    @(posedge clk) disable iff (!rst_n)
    (is_master && cfg_a_reg[`ACM_B_GATE]) [*2] |-> !bclk_o && !fsync_o;
  endproperty
  a_gate: assert property (p_gate)
    else $error("gated clocks still toggling");

  property p_family;
    @(posedge clk) disable iff (!rst_n)
    $changed(cfg_a_reg[`ACM_B_FAM]) |=> rate_family == cfg_a_reg[`ACM_B_FAM];
  endproperty
  a_family: assert property (p_family)
    else $error("rate family output lags its bit");

  property p_ref_valid;
    @(posedge clk) disable iff (!rst_n)
    ref_freq_valid |-> $past(is_master) && !$past(ref_reg[`ACM_B_REFMODE]);
  endproperty
  a_ref_valid: assert property (p_ref_valid)
    else $error("reference code valid outside master mode zero");

  property p_ref_excl;
    @(posedge clk) disable iff (!rst_n)
    !(ref_freq_valid && ref_ratio_valid);
  endproperty
  a_ref_excl: assert property (p_ref_excl)
    else $error("both reference sources claimed at once");

  property p_sts_read;
    @(posedge clk) disable iff (!rst_n)
    (acc_phase && !hwrite && addr_ok && idx == `ACM_IDX_STS) |=>
      hrdata == {24'h00_0000, $past(sts)};
  endproperty
  a_sts_read: assert property (p_sts_read)
    else $error("status read returns wrong value");

  property p_sts_ro;
    @(posedge clk) disable iff (!rst_n)
    (wr_pend_reg && wr_idx_reg == `ACM_IDX_STS) |=>
      (cfg_a_reg == $past(cfg_a_reg)) && (cfg_b_reg == $past(cfg_b_reg)) &&
      (ref_reg == $past(ref_reg));
  endproperty
  a_sts_ro: assert property (p_sts_ro)
    else $error("write to status disturbed another register");

  property p_slave_ignore;
    @(posedge clk) disable iff (!rst_n)
    (!is_master && is_auto) |=> !frame_cfg_used && !bclk_oe;
  endproperty
  a_slave_ignore: assert property (p_slave_ignore)
    else $error("frame settings used in slave auto mode");

  property p_pll_on;
    @(posedge clk) disable iff (!rst_n)
    ($past(rst_n) && is_auto && !cfg_a_reg[`ACM_B_PLLDIS]) |=> pll_en;
  endproperty
  a_pll_on: assert property (p_pll_on)
    else $error("pll stopped while auto mode wants it");

  property p_ref_code;
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> ref_freq_code == $past(cfg_a_reg[`ACM_F_REFC]);
  endproperty
  a_ref_code: assert property (p_ref_code)
    else $error("reference code output lags its field");

  property p_slave_quiet;
    @(posedge clk) disable iff (!rst_n)
    !is_master |=> !bclk_o && !fsync_o;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet)
    else $error("clocks generated in slave mode");

  // reserved codes must hold both generated clocks low from the next cycle
  property p_reserved_stop;
    @(posedge clk) disable iff (!rst_n)
    ((cfg_b_reg[`ACM_F_RATE] > `ACM_RATE_MAX) ||
      (cfg_b_reg[`ACM_F_RATIO] > `ACM_RATIO_MAX)) |=> !bclk_o && !fsync_o;
  endproperty
  a_reserved_stop: assert property (p_reserved_stop)
    else $error("clocks run on a reserved rate or ratio code");

endmodule : acm_top
`default_nettype wire

// ==== acm_host.sv ====
// Purpose: far side bus master driving bit clock and frame sync
// Assumes: enabled only while the device is bus slave
// Notes: clocks stand still while disabled
`timescale 1ns/1ps
`default_nettype none
module acm_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic en,
  input wire logic [7:0] half,
  input wire logic [11:0] ratio,
  // port clocks
  output logic bclk,
  output logic fsync
);
  logic [7:0] hcnt_reg;
  logic [11:0] bit_reg;
  // while enabled, frame sync moves only with the falling bit clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hcnt_reg <= 8'h00;
      bit_reg <= 12'h000;
      bclk <= 1'b0;
      fsync <= 1'b0;
    end else if (!en) begin
      hcnt_reg <= 8'h00;
      bit_reg <= 12'h000;
      bclk <= 1'b0;
      fsync <= 1'b1;
    end else if (hcnt_reg == half - 8'h01) begin
      hcnt_reg <= 8'h00;
      bclk <= !bclk;
      if (bclk) begin
        // only documented ratios are ever passed in
        bit_reg <= (bit_reg == ratio - 12'h001) ? 12'h000 : bit_reg + 12'h001;
        fsync <= (bit_reg == ratio - 12'h001);
      end
    end else begin
      hcnt_reg <= hcnt_reg + 8'h01;
    end
  end
endmodule : acm_host
`default_nettype wire

// ==== acm_top_bench.sv ====
// Purpose: self-checking bench of the audio port clock block
// Assumes: one bus slave, hready looped back
// Notes: expectations queue up, a watcher compares
`timescale 1ns/1ps
`default_nettype none
module acm_top_bench import acm_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, h_en = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, bclk_o, bclk_oe, fsync_o, fsync_oe;
  logic auto_clk_en, pll_en, rate_family, ref_freq_valid;
  logic ref_ratio_valid, frame_cfg_used, h_bclk, h_fsync, fam;
  logic [2:0] ref_freq_code, ref_ratio_code;
  wire logic bclk_w = bclk_oe ? bclk_o : h_bclk;
  wire logic fsync_w = fsync_oe ? fsync_o : h_fsync;
  int num_errors = 0, total_checks = 0, k, seed;
  logic [31:0] exp_q[$], got_q[$], e, g;
  string nm_q[$], s;
  logic [7:0] cfg_t [3] = '{8'h80, 8'h42, 8'h57};
  int rat_t [3] = '{16, 32, 192};
  always #10 clk = ~clk;
  acm_top #(.MON_LIMIT(2000)) i_dut (.clk(clk), .rst_n(rst_n),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .bclk_i(bclk_w), .bclk_o(bclk_o), .bclk_oe(bclk_oe),
    .fsync_i(fsync_w), .fsync_o(fsync_o), .fsync_oe(fsync_oe),
    .auto_clk_en(auto_clk_en), .pll_en(pll_en),
    .rate_family(rate_family), .ref_freq_valid(ref_freq_valid),
    .ref_freq_code(ref_freq_code), .ref_ratio_valid(ref_ratio_valid),
    .ref_ratio_code(ref_ratio_code), .frame_cfg_used(frame_cfg_used));
  acm_host i_host (.clk(clk), .rst_n(rst_n), .en(h_en),
    .half(8'd16), .ratio(12'd32), .bclk(h_bclk), .fsync(h_fsync));
  ////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    #1;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic expect_v(input string nm, input logic [31:0] v);
    nm_q.push_back(nm);
    exp_q.push_back(v);
  endtask : expect_v
  task automatic see(input string nm, input logic [31:0] v,
      input logic [31:0] o);
    expect_v(nm, v);
    got_q.push_back(o);
  endtask : see
  task automatic bus(input logic [7:0] idx, input logic we,
      input logic [31:0] wd);
    int n;
    n = 0;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= we;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin num_errors++; stop_test(); end
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, {24'h0, d});
    repeat (2) @(posedge clk);
  endtask : wr
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] v);
    expect_v($sformatf("reg %h", idx), v);
    bus(idx, 1'b0, 32'h0);
    got_q.push_back(rd);
  endtask : rdchk
  // bit clock rises between two frame sync rises
  task automatic count_frame(output int c);
    int n;
    logic pb, pf;
    c = 0;
    n = 0;
    do begin pf = fsync_w; @(posedge clk); n++; end
    while (!(fsync_w && !pf) && n < 9000);
    do begin
      pf = fsync_w;
      pb = bclk_w;
      @(posedge clk);
      n++;
      if (bclk_w && !pb) c++;
    end while (!(fsync_w && !pf) && n < 9000);
    if (n >= 9000) begin num_errors++; stop_test(); end
  endtask : count_frame
  ////////////////////////////////////////////////////////////////////
  initial forever begin
    wait (got_q.size() > 0);
    g = got_q.pop_front();
    e = exp_q.pop_front();
    s = nm_q.pop_front();
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  initial begin
    seed = $urandom(32'h8114);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(8'h13, 32'h02);
    rdchk(8'h14, 32'h48);
    rdchk(8'h15, 32'hFF);
    see("auto", 1, 32'(auto_clk_en));
    see("pll", 1, 32'(pll_en));
    see("oe", 0, 32'(bclk_oe));
    see("hresp", 0, 32'(hresp));
    see("ready", 1, 32'(hreadyout));
    rdchk(8'h30, 32'h0);
    wr(8'h15, 8'h00);
    rdchk(8'h15, 32'hFF);
    for (int c = 0; c < 8; c++) begin
      fam = 1'($urandom_range(1, 0));
      wr(8'h13, {4'h9, fam, 3'(c)});
      see("refc", 32'(c), 32'(ref_freq_code));
      see("refv", 1, 32'(ref_freq_valid));
      see("fam", 32'(fam), 32'(rate_family));
    end
    wr(8'h16, 8'h0D);
    see("refv", 0, 32'(ref_freq_valid));
    see("ratv", 1, 32'(ref_ratio_valid));
    see("ratc", 5, 32'(ref_ratio_code));
    wr(8'h16, 8'h02);
    wr(8'h13, 8'hC0);
    see("auto", 0, 32'(auto_clk_en));
    see("refv", 0, 32'(ref_freq_valid));
    wr(8'h13, 8'h20);
    see("pll", 0, 32'(pll_en));
    see("used", 0, 32'(frame_cfg_used));
    for (int i = 0; i < 3; i++) begin
      wr(8'h14, cfg_t[i]);
      wr(8'h13, 8'h82);
      count_frame(k);
      count_frame(k);
      see("bits", 32'(rat_t[i]), 32'(k));
      see("oe", 1, 32'(bclk_oe));
      see("fsoe", 1, 32'(fsync_oe));
      count_frame(k);
      rdchk(8'h15, 32'(cfg_t[i]));
    end
    wr(8'h13, 8'h92);
    k = 0;
    repeat (200) begin
      @(posedge clk);
      if (bclk_o !== 1'b0 || fsync_o !== 1'b0) k++;
    end
    see("gated", 0, 32'(k));
    wr(8'h14, 8'h9D);
    wr(8'h13, 8'h82);
    k = 0;
    repeat (200) begin @(posedge clk); k += int'(bclk_o !== 1'b0); end
    see("reserved", 0, 32'(k));
    wr(8'h13, 8'h02);
    h_en <= 1'b1;
    see("used", 0, 32'(frame_cfg_used));
    see("oe", 0, 32'(bclk_oe));
    see("fsoe", 0, 32'(fsync_oe));
    repeat (4) count_frame(k);
    rdchk(8'h15, 32'h42);
    wr(8'h13, 8'h42);
    see("used", 1, 32'(frame_cfg_used));
    h_en <= 1'b0;
    repeat (2100) @(posedge clk);
    rdchk(8'h15, 32'hFF);
    stop_test();
  end
endmodule : acm_top_bench
`default_nettype wire
